/* File: pkg/console_pkg.sv */
// Shared constants, types and decode helpers of the console panel logic
`default_nettype none
package console_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int WORD_W   = 16;
  localparam int NUM_REGS = 5;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0]  CTRL_OFS    = 8'h00;
  localparam logic [7:0]  STATUS_OFS  = 8'h04;
  localparam logic [7:0]  DISPLAY_OFS = 8'h08;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

  // CTRL fields: bits 0..2 self-clearing requests, 3..4 stored
  localparam int CTRL_STEP_BIT   = 0;
  localparam int CTRL_RUN_BIT    = 1;
  localparam int CTRL_SYSRST_BIT = 2;
  localparam int CTRL_REPEAT_BIT = 3;
  localparam int CTRL_LOCK_BIT   = 4;

  // STATUS fields
  localparam int ST_OVERFLOW_LAMP_BIT   = 0;
  localparam int ST_STEP_BIT   = 1;
  localparam int ST_RUN_BIT    = 2;
  localparam int ST_BUSY_BIT   = 3;
  localparam int ST_SELOK_BIT  = 4;
  localparam int ST_LOCK_BIT   = 5;
  localparam int ST_REPEAT_BIT = 6;

  // One-hot positions of the register select switches
  localparam int SEL_X = 0;
  localparam int SEL_B = 1;
  localparam int SEL_A = 2;
  localparam int SEL_U = 3;
  localparam int SEL_P = 4;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [NUM_REGS-1:0] sel;
    logic [WORD_W-1:0]   data;
    logic                clear;
    logic                step;
    logic                run;
    logic                sysRst;
    logic                repeatSw;
    logic [2:0]          sense;
    logic                lock;
  } panel_t;

  typedef enum logic [1:0] {
    MODE_HALT,
    MODE_STEP_BUSY,
    MODE_RUN,
    MODE_RUN_STOPPING
  } mode_t;

  // Exactly one select switch down
  function automatic logic sel_valid(input logic [NUM_REGS-1:0] s);
    return $onehot(s);
  endfunction

endpackage
`default_nettype wire

/* File: pkg/panel_if.sv */
// Synchronised panel switch bundle between synchroniser and control logic
`default_nettype none
interface panel_if;
  console_pkg::panel_t sw;
  modport src (output sw);
  modport dst (input  sw);
endinterface
`default_nettype wire

/* File: hdl/switch_sync.sv */
// Two-stage synchroniser for every front panel switch
`default_nettype none
module switch_sync (
  input  wire logic                core_clk,
  input  wire logic                rstn,
  input  wire console_pkg::panel_t rawSw,
  panel_if.src                     out
);

  typedef struct packed {
    console_pkg::panel_t stage1;
    console_pkg::panel_t stage2;
  } sync_t;

  sync_t syncReg;
  sync_t syncNext;

  always_comb
  begin
    syncNext        = syncReg;
    syncNext.stage1 = rawSw;
    syncNext.stage2 = syncReg.stage1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      syncReg <= '0;
    else
      syncReg <= syncNext;
  end

  assign out.sw = syncReg.stage2;

endmodule
`default_nettype wire

/* File: hdl/lamp_driver.sv */
// Selected register onto the sixteen display lamps
`default_nettype none
module lamp_driver (
  input  wire logic                                     core_clk,
  input  wire logic                                     rstn,
  input  wire logic [console_pkg::NUM_REGS-1:0]         sel,
  input  wire logic [console_pkg::WORD_W-1:0]           regX,
  input  wire logic [console_pkg::WORD_W-1:0]           regB,
  input  wire logic [console_pkg::WORD_W-1:0]           regA,
  input  wire logic [console_pkg::WORD_W-1:0]           regU,
  input  wire logic [console_pkg::WORD_W-1:0]           regP,
  output logic      [console_pkg::WORD_W-1:0]           lamps
);

  typedef struct packed {
    logic [console_pkg::WORD_W-1:0] lamps;
  } lamp_t;

  lamp_t lampReg;
  lamp_t lampNext;

  // Lamp 15 is the sign bit at the left end, lamp 0 at the right
  always_comb
  begin
    lampNext = lampReg;
    if (!console_pkg::sel_valid(sel))
      lampNext.lamps = '0;
    else
    begin
      case (1'b1)
        sel[console_pkg::SEL_X]: lampNext.lamps = regX;
        sel[console_pkg::SEL_B]: lampNext.lamps = regB;
        sel[console_pkg::SEL_A]: lampNext.lamps = regA;
        sel[console_pkg::SEL_U]: lampNext.lamps = regU;
        sel[console_pkg::SEL_P]: lampNext.lamps = regP;
        default:                 lampNext.lamps = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      lampReg <= '0;
    else
      lampReg <= lampNext;
  end

  assign lamps = lampReg.lamps;

endmodule
`default_nettype wire

/* File: hdl/console_panel_step_control.sv */
// Operator console control: selection, entry, run/step/halt, repeat, sense
//
// Behaviour
// - One of five registers selected for display; several selected blanks the display.
// - Data switches set bits in the selected register only when halted in step mode.
// - Sixteen lamps show the selected register, sign bit leftmost, bit 0 rightmost.
// - Clear zeroes the selected register and does nothing in run mode.
// - Lamps for overflow flip-flop, step mode and run mode.
// - Step while halted executes the held instruction once per press.
// - Step while running finishes the current instruction then halts in step mode.
// - Run executes the held instruction then continues from the program counter.
// - System reset halts, clears processor control and initialises all peripherals.
// - Repeat step executes, advances program counter, keeps instruction register.
// - Repeat acts only when halted in step mode, never on run fetching.
// - Sense jumps and executes succeed only when their sense switch is on.
// - Normal step fetches the instruction at the program counter afterwards.
// - A step ends only when the core reports the whole instruction done or a system reset halts it.
// - The lock key disables all console controls except the select and sense switches without disturbing execution.
// - Repeated relative store writes consecutive locations as the counter advances.
// - Halted, the instruction register holds the next instruction to execute.
`default_nettype none
module console_panel_step_control (
  input  wire logic                                 core_clk,
  input  wire logic                                 rstn,
  // Front panel switches, asynchronous
  input  wire logic [console_pkg::NUM_REGS-1:0]     selSw,
  input  wire logic [console_pkg::WORD_W-1:0]       dataSw,
  input  wire logic                                 clearSw,
  input  wire logic                                 stepSw,
  input  wire logic                                 runSw,
  input  wire logic                                 sysResetSw,
  input  wire logic                                 repeatSw,
  input  wire logic [2:0]                           senseSw,
  input  wire logic                                 lockKey,
  // Processor core, same clock
  input  wire logic [console_pkg::WORD_W-1:0]       regX,
  input  wire logic [console_pkg::WORD_W-1:0]       regB,
  input  wire logic [console_pkg::WORD_W-1:0]       regA,
  input  wire logic [console_pkg::WORD_W-1:0]       regU,
  input  wire logic [console_pkg::WORD_W-1:0]       regP,
  input  wire logic                                 overflowFf,
  input  wire logic                                 instrDone,
  input  wire logic [1:0]                           senseQuery,
  output logic                                      coreExec,
  output logic                                      coreRun,
  output logic                                      coreFetchInhibit,
  output logic                                      coreSysReset,
  output logic                                      periphReset,
  output logic                                      regWrEn,
  output logic      [console_pkg::NUM_REGS-1:0]     regWrSel,
  output logic      [console_pkg::WORD_W-1:0]       regWrData,
  output logic                                      senseTrue,
  // Lamps
  output logic      [console_pkg::WORD_W-1:0]       displayLamps,
  output logic                                      overflowLamp,
  output logic                                      stepLamp,
  output logic                                      runLamp,
  // APB slave
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [console_pkg::ADDR_W-1:0]       paddr,
  input  wire logic [console_pkg::DATA_W-1:0]       pwdata,
  input  wire logic [3:0]                           pstrb,
  output logic      [console_pkg::DATA_W-1:0]       prdata,
  output logic                                      pready,
  output logic                                      pslverr
);

  // ****************************************
  // Switch synchroniser and lamp driver
  // ****************************************
  panel_if             panel ();
  console_pkg::panel_t rawSw;

  assign rawSw = '{sel:      selSw,
                   data:     dataSw,
                   clear:    clearSw,
                   step:     stepSw,
                   run:      runSw,
                   sysRst:   sysResetSw,
                   repeatSw: repeatSw,
                   sense:    senseSw,
                   lock:     lockKey};

  switch_sync u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .rawSw    (rawSw),
    .out      (panel.src)
  );

  lamp_driver u_lamps (
    .core_clk (core_clk),
    .rstn     (rstn),
    .sel      (panel.sw.sel),
    .regX     (regX),
    .regB     (regB),
    .regA     (regA),
    .regU     (regU),
    .regP     (regP),
    .lamps    (displayLamps)
  );

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    console_pkg::mode_t             mode;
    console_pkg::panel_t            prev;
    logic                           repeatSoft;
    logic                           lockSoft;
    logic                           softStep;
    logic                           softRun;
    logic                           softSys;
    logic                           stopWait;
    logic                           coreExec;
    logic                           coreRun;
    logic                           coreFetchInhibit;
    logic                           coreSysReset;
    logic                           periphReset;
    logic                           regWrEn;
    logic [console_pkg::NUM_REGS-1:0] regWrSel;
    logic [console_pkg::WORD_W-1:0] regWrData;
    logic                           senseTrue;
    logic                           overflowLamp;
    logic                           stepLamp;
    logic                           runLamp;
    logic [console_pkg::DATA_W-1:0] prdata;
    logic                           pready;
    logic                           pslverr;
  } state_t;

  state_t stateReg;
  state_t stateNext;

  console_pkg::panel_t            sw;
  logic                           panelOn;
  logic                           repeatOn;
  logic                           stepReq;
  logic                           runReq;
  logic                           sysReq;
  logic                           clearEdge;
  logic [console_pkg::WORD_W-1:0] dataEdge;
  logic                           apbWrite;

  assign sw = panel.sw;

  always_comb
  begin
    stateNext = stateReg;
    stateNext.prev         = sw;
    stateNext.softStep     = 1'b0;
    stateNext.softRun      = 1'b0;
    stateNext.softSys      = 1'b0;
    stateNext.stopWait     = 1'b0;
    stateNext.coreExec     = 1'b0;
    stateNext.coreSysReset = 1'b0;
    stateNext.periphReset  = 1'b0;
    stateNext.regWrEn      = 1'b0;

    // ****************************************
    // Panel events
    // ****************************************
    panelOn   = !(sw.lock || stateReg.lockSoft);
    repeatOn  = (panelOn && sw.repeatSw) || stateReg.repeatSoft;
    stepReq   = (panelOn && sw.step && !stateReg.prev.step) || stateReg.softStep;
    runReq    = (panelOn && sw.run && !stateReg.prev.run) || stateReg.softRun;
    sysReq    = (panelOn && sw.sysRst && !stateReg.prev.sysRst) || stateReg.softSys;
    clearEdge = panelOn && sw.clear && !stateReg.prev.clear;
    dataEdge  = panelOn ? (sw.data & ~stateReg.prev.data) : '0;

    // ****************************************
    // Run / step / halt sequencing
    // ****************************************
    if (sysReq)
    begin
      stateNext.mode             = console_pkg::MODE_HALT;
      stateNext.coreRun          = 1'b0;
      stateNext.coreFetchInhibit = 1'b0;
      stateNext.coreSysReset     = 1'b1;
      stateNext.periphReset      = 1'b1;
    end
    else
    begin
      case (stateReg.mode)
        console_pkg::MODE_HALT:
        begin
          if (runReq)
          begin
            stateNext.coreExec         = 1'b1;
            stateNext.coreRun          = 1'b1;
            stateNext.coreFetchInhibit = 1'b0;
            stateNext.mode             = console_pkg::MODE_RUN;
          end
          else if (stepReq)
          begin
            stateNext.coreExec         = 1'b1;
            stateNext.coreFetchInhibit = repeatOn;
            stateNext.mode             = console_pkg::MODE_STEP_BUSY;
          end
        end
        console_pkg::MODE_STEP_BUSY:
        begin
          if (instrDone)
          begin
            stateNext.coreFetchInhibit = 1'b0;
            stateNext.mode             = console_pkg::MODE_HALT;
          end
        end
        console_pkg::MODE_RUN:
        begin
          if (stepReq)
          begin
            stateNext.coreRun  = 1'b0;
            stateNext.stopWait = 1'b1;
            stateNext.mode     = console_pkg::MODE_RUN_STOPPING;
          end
        end
        console_pkg::MODE_RUN_STOPPING:
        begin
          // A done in the first cycle here, while stopWait is set, ended an instruction that saw run still up
          if (instrDone && !stateReg.stopWait)
            stateNext.mode = console_pkg::MODE_HALT;
        end
        default:
        begin
          stateNext.mode    = console_pkg::MODE_HALT;
          stateNext.coreRun = 1'b0;
        end
      endcase
    end

    // ****************************************
    // Manual entry and clear of the selected register
    // ****************************************
    if (!sysReq && stateReg.mode == console_pkg::MODE_HALT
        && stateNext.mode == console_pkg::MODE_HALT
        && console_pkg::sel_valid(sw.sel))
    begin
      if (clearEdge)
      begin
        stateNext.regWrEn   = 1'b1;
        stateNext.regWrSel  = sw.sel;
        stateNext.regWrData = '0;
      end
      else if (|dataEdge)
      begin
        stateNext.regWrEn   = 1'b1;
        stateNext.regWrSel  = sw.sel;
        stateNext.regWrData = displayLamps | dataEdge;
      end
    end

    // ****************************************
    // Sense switch conditioning and status lamps
    // ****************************************
    case (senseQuery)
      2'h1:    stateNext.senseTrue = sw.sense[0];
      2'h2:    stateNext.senseTrue = sw.sense[1];
      2'h3:    stateNext.senseTrue = sw.sense[2];
      default: stateNext.senseTrue = 1'b0;
    endcase

    stateNext.overflowLamp = overflowFf;
    stateNext.stepLamp     = (stateNext.mode == console_pkg::MODE_HALT)
                          || (stateNext.mode == console_pkg::MODE_STEP_BUSY);
    stateNext.runLamp      = (stateNext.mode == console_pkg::MODE_RUN)
                          || (stateNext.mode == console_pkg::MODE_RUN_STOPPING);

    // ****************************************
    // APB slave: answer prepared in setup, one access cycle
    // ****************************************
    apbWrite = psel && penable && stateReg.pready && pwrite && !stateReg.pslverr;
    if (apbWrite && pstrb[0] && paddr == console_pkg::CTRL_OFS)
    begin
      stateNext.softStep   = pwdata[console_pkg::CTRL_STEP_BIT];
      stateNext.softRun    = pwdata[console_pkg::CTRL_RUN_BIT];
      stateNext.softSys    = pwdata[console_pkg::CTRL_SYSRST_BIT];
      stateNext.repeatSoft = pwdata[console_pkg::CTRL_REPEAT_BIT];
      stateNext.lockSoft   = pwdata[console_pkg::CTRL_LOCK_BIT];
    end

    if (psel && !penable)
    begin
      stateNext.pready  = 1'b1;
      stateNext.pslverr = 1'b0;
      stateNext.prdata  = '0;
      case (paddr)
        console_pkg::CTRL_OFS:
        begin
          stateNext.prdata[console_pkg::CTRL_REPEAT_BIT] = stateReg.repeatSoft;
          stateNext.prdata[console_pkg::CTRL_LOCK_BIT]   = stateReg.lockSoft;
        end
        console_pkg::STATUS_OFS:
        begin
          stateNext.prdata[console_pkg::ST_OVERFLOW_LAMP_BIT]   = stateReg.overflowLamp;
          stateNext.prdata[console_pkg::ST_STEP_BIT]   = stateReg.stepLamp;
          stateNext.prdata[console_pkg::ST_RUN_BIT]    = stateReg.runLamp;
          stateNext.prdata[console_pkg::ST_BUSY_BIT]   =
            stateReg.mode != console_pkg::MODE_HALT;
          stateNext.prdata[console_pkg::ST_SELOK_BIT]  = console_pkg::sel_valid(sw.sel);
          stateNext.prdata[console_pkg::ST_LOCK_BIT]   = !panelOn;
          stateNext.prdata[console_pkg::ST_REPEAT_BIT] = repeatOn;
        end
        console_pkg::DISPLAY_OFS:
          stateNext.prdata[console_pkg::WORD_W-1:0] = displayLamps;
        default:
          stateNext.pslverr = 1'b1;
      endcase
    end
    else
    begin
      stateNext.pready  = 1'b0;
      stateNext.pslverr = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      stateReg <= '0;
    else
      stateReg <= stateNext;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign coreExec         = stateReg.coreExec;
  assign coreRun          = stateReg.coreRun;
  assign coreFetchInhibit = stateReg.coreFetchInhibit;
  assign coreSysReset     = stateReg.coreSysReset;
  assign periphReset      = stateReg.periphReset;
  assign regWrEn          = stateReg.regWrEn;
  assign regWrSel         = stateReg.regWrSel;
  assign regWrData        = stateReg.regWrData;
  assign senseTrue        = stateReg.senseTrue;
  assign overflowLamp     = stateReg.overflowLamp;
  assign stepLamp         = stateReg.stepLamp;
  assign runLamp          = stateReg.runLamp;
  assign prdata           = stateReg.prdata;
  assign pready           = stateReg.pready;
  assign pslverr          = stateReg.pslverr;

endmodule
`default_nettype wire

/* File: verification/cpsc_asserts.sv */
// Port-level property checks of the console control block
`default_nettype none
module cpsc_asserts (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic [4:0]  selSw,
  input wire logic [2:0]  senseSw,
  input wire logic        lockKey,
  input wire logic [15:0] regA,
  input wire logic        overflowFf,
  input wire logic        instrDone,
  input wire logic [1:0]  senseQuery,
  input wire logic        coreExec,
  input wire logic        coreRun,
  input wire logic        coreFetchInhibit,
  input wire logic        coreSysReset,
  input wire logic        regWrEn,
  input wire logic        senseTrue,
  input wire logic [15:0] displayLamps,
  input wire logic        overflowLamp,
  input wire logic        stepLamp,
  input wire logic        runLamp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ****
  // Checks
  // ****
  blank_sel_a: assert property (!$onehot(selSw) [*5] |=> displayLamps == 16'h0)
    else $error("display not blank");
  show_reg_a: assert property ((selSw == 5'h04 && $stable(regA)) [*5] |-> displayLamps == regA)
    else $error("display differs");
  exec_once_a: assert property (coreExec |=> !coreExec)
    else $error("long exec pulse");
  run_lamp_a: assert property (coreRun |-> runLamp && !stepLamp)
    else $error("run lamps wrong");
  overflow_lamp_lamp_a: assert property (overflowFf [*2] |-> overflowLamp)
    else $error("overflow lamp off");
  run_lock_a: assert property (runLamp |-> !regWrEn)
    else $error("write in run");
  lock_key_a: assert property (lockKey [*6] |-> !regWrEn)
    else $error("write while locked");
  sys_rst_a: assert property (coreSysReset |=> !coreRun && !runLamp)
    else $error("run after reset");
  halt_done_a: assert property (instrDone && !coreRun && !$past(coreRun)
    |=> stepLamp && !coreFetchInhibit)
    else $error("no halt after done");
  run_fetch_a: assert property (coreRun |-> !coreFetchInhibit)
    else $error("fetch inhibited in run");
  sense_sw_a: assert property (
    (senseQuery != 2'h0 && $stable(senseQuery) && $stable(senseSw)) [*5]
    |-> senseTrue == senseSw[senseQuery - 2'h1])
    else $error("sense wrong");
  c_rep: cover property (coreExec && coreFetchInhibit);
  c_run: cover property ($rose(coreRun));
  c_rst: cover property (coreSysReset);
endmodule
`default_nettype wire

/* File: verification/core_model.sv */
// Behavioural processor core facing the console
`default_nettype none
module core_model (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  lat,
  input  wire logic        coreExec,
  input  wire logic        coreRun,
  input  wire logic        coreFetchInhibit,
  input  wire logic        coreSysReset,
  input  wire logic        regWrEn,
  input  wire logic [4:0]  regWrSel,
  input  wire logic [15:0] regWrData,
  output logic      [15:0] r [5],
  output logic             instrDone
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       busy;
  logic [3:0] cnt;
  always_ff @(posedge core_clk)
  begin
    instrDone <= 1'b0;
    if (!rstn)
    begin
      busy <= 1'b0;
      cnt  <= 4'h0;
      r    <= '{default: 16'h0};
    end
    else if (coreSysReset)
      busy <= 1'b0;
    else if (coreExec)
    begin
      busy <= 1'b1;
      cnt  <= lat;
    end
    else if (busy && cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else if (busy)
    begin
      instrDone <= 1'b1;
      busy      <= coreRun;
      cnt       <= lat;
      r[4]      <= r[4] + 16'h1;
      if (!coreFetchInhibit)
        r[3] <= ~r[4];
    end
    if (rstn && regWrEn)
      for (int i = 0; i < 5; i++)
        if (regWrSel[i])
          r[i] <= regWrData;
  end
endmodule
`default_nettype wire

/* File: verification/console_panel_step_control_tb.sv */
// Self-checking bench of the console control block
`default_nettype none
module console_panel_step_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0]  selSw = 5'h0;
  logic [15:0] dataSw = 16'h0;
  logic [2:0]  senseSw = 3'h0;
  logic [1:0]  senseQuery = 2'h0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf, lat = 4'h5;
  logic        core_clk = 1'b0, rstn = 1'b0, clearSw = 1'b0, stepSw = 1'b0, runSw = 1'b0;
  logic        sysResetSw = 1'b0, repeatSw = 1'b0, lockKey = 1'b0, overflowFf = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [15:0] r [5];
  logic [15:0] regWrData, displayLamps;
  logic [31:0] prdata, rd;
  logic [4:0]  regWrSel;
  logic        coreExec, coreRun, coreFetchInhibit, coreSysReset, periphReset, regWrEn;
  logic        senseTrue, overflowLamp, stepLamp, runLamp, pready, pslverr, instrDone;
  int          fail_count = 0, n_compared = 0, nExec = 0, nPer = 0, e;

  console_panel_step_control i_dut (
    .core_clk, .rstn, .selSw, .dataSw, .clearSw, .stepSw, .runSw, .sysResetSw, .repeatSw,
    .senseSw, .lockKey, .regX(r[0]), .regB(r[1]), .regA(r[2]), .regU(r[3]), .regP(r[4]),
    .overflowFf, .instrDone, .senseQuery, .coreExec, .coreRun, .coreFetchInhibit,
    .coreSysReset, .periphReset, .regWrEn, .regWrSel, .regWrData, .senseTrue,
    .displayLamps, .overflowLamp, .stepLamp, .runLamp, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr);
  core_model i_core (.core_clk, .rstn, .lat, .coreExec, .coreRun, .coreFetchInhibit,
    .coreSysReset, .regWrEn, .regWrSel, .regWrData, .r, .instrDone);

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    nExec += (coreExec === 1'b1);
    nPer  += (periphReset === 1'b1);
  end
  // ****
  // Tasks
  // ****
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x)
    begin
      fail_count++;
      $display("ERROR %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic final_report();
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Momentary keys: {system reset, run, step, clear}
  task automatic press(input logic [3:0] m, input logic [15:0] d);
    {sysResetSw, runSw, stepSw, clearSw} <= m;
    dataSw <= d;
    cyc(6);
    {sysResetSw, runSw, stepSw, clearSw} <= 4'h0;
    dataSw <= 16'h0;
    cyc(7);
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge core_clk);
      t++;
    end
    while (pready !== 1'b1 && t < 20);
    rd = prdata;
    err = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_entry();
    selSw <= 5'h04;
    press(4'h0, 16'h8005);
    chk("regA", 16'h8005, r[2]);
    chk("lamps", 16'h8005, displayLamps);
    selSw <= 5'h14;
    press(4'h1, 16'h0);
    chk("blank", 16'h0, displayLamps);
    chk("regA kept", 16'h8005, r[2]);
    selSw <= 5'h04;
    press(4'h1, 16'h0);
    chk("cleared", 16'h0, r[2]);
  endtask
  task automatic t_step();
    selSw <= 5'h10;
    press(4'h0, 16'h0010);
    e = nExec;
    press(4'h2, 16'h0);
    chk("execs", e + 1, nExec);
    chk("P", 16'h0011, r[4]);
    chk("U", 16'hffef, r[3]);
    chk("stepLamp", 1, stepLamp);
    repeatSw <= 1'b1;
    lat <= 4'h0;
    press(4'h2, 16'h0);
    press(4'h2, 16'h0);
    chk("P rep", 16'h0013, r[4]);
    chk("U rep", 16'hffef, r[3]);
  endtask
  task automatic t_run();
    lat <= 4'h3;
    selSw <= 5'h04;
    press(4'h4, 16'h0);
    chk("runLamp", 1, runLamp);
    chk("P moves", 1, r[4] > 16'h0014);
    chk("U run", 1, r[3] != 16'hffef);
    press(4'h0, 16'h00ff);
    chk("A run", 16'h0, r[2]);
    press(4'h2, 16'h0);
    chk("halted", 1, stepLamp);
    chk("run off", 0, runLamp);
    e = nPer;
    press(4'h4, 16'h0);
    press(4'h8, 16'h0);
    chk("periph", e + 1, nPer);
    chk("rst step", 1, stepLamp);
  endtask
  task automatic t_misc();
    lockKey <= 1'b1;
    cyc(4);
    e = nExec;
    press(4'h2, 16'h0300);
    chk("lock exec", e, nExec);
    chk("lock A", 16'h0, r[2]);
    apb(8'h00, 1'b1, 32'h1);
    cyc(8);
    chk("soft exec", e + 1, nExec);
    lockKey <= 1'b0;
    overflowFf <= 1'b1;
    cyc(3);
    chk("overflow_lamp", 1, overflowLamp);
    apb(8'h04, 1'b0, 32'h0);
    chk("status", 32'h3, rd & 32'h7);
    apb(8'h40, 1'b0, 32'h0);
    chk("slverr", 1, err);
    senseSw <= 3'h5;
    for (int q = 1; q < 4; q++)
    begin
      senseQuery <= q[1:0];
      cyc(6);
      chk("sense", q != 2, senseTrue);
    end
  endtask

  initial
  begin
    cyc(12);
    rstn <= 1'b1;
    cyc(2);
    t_entry();
    t_step();
    t_run();
    t_misc();
    final_report();
  end
  initial
  begin
    cyc(5000);
    fail_count++;
    final_report();
  end
endmodule

bind console_panel_step_control cpsc_asserts i_chk (.core_clk, .rstn, .selSw, .senseSw,
  .lockKey, .regA, .overflowFf, .instrDone, .senseQuery, .coreExec, .coreRun,
  .coreFetchInhibit, .coreSysReset, .regWrEn, .senseTrue, .displayLamps, .overflowLamp,
  .stepLamp, .runLamp);
`default_nettype wire
